/* rtl/dsk_map.vh */
// Constants for the double slot key stream XOR block
// Assumes inclusion by bare name from every design file
`ifndef DSK_MAP_VH
`define DSK_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets (word aligned)
`define DSK_OFF_CTRL     8'h00
`define DSK_OFF_MODE     8'h04
`define DSK_OFF_BMAP     8'h08
`define DSK_OFF_CMAP     8'h0C
`define DSK_OFF_STATUS   8'h10

// Field positions
`define DSK_CTRL_PT      0
`define DSK_MODE_ON      8
`define DSK_STAT_OK      16
`define DSK_STAT_UNDER   17

// Reset values
`define DSK_RST_CTRL     32'h0000_0000
`define DSK_RST_MAP      24'h00_0000

////////////////////////////////////////////////////////////////////////////////
// B-field formats
`define DSK_FMT_UNPROT   2'h0
`define DSK_FMT_SINGLE   2'h1
`define DSK_FMT_MULTI    2'h2

// Bit positions within one data field (A-field first, then B-field)
`define DSK_A_KEY_FIRST  10'h008
`define DSK_A_KEY_LAST   10'h02F
`define DSK_A_LEN        10'h040
`define DSK_B_KEY_LEN    10'h320
`define DSK_SINGLE_DATA  10'h300
`define DSK_SUB_LEN      10'h050
`define DSK_SUB_DATA     10'h040
`define DSK_NSUB         10
`define DSK_LAST_UNPROT  10'h35F
`define DSK_LAST_PROT    10'h363

// Key stream lengths
`define DSK_SEG_LEN      11'h348
`define DSK_PAIR_LEN     11'h690

`endif

/* rtl/dsk_bit_map.v */
// Position decoder: which field bits use key and which are XORed
// Assumes position 0 is A-field bit 0 and position 64 is B-field bit 0
`timescale 1ns/1ps
`include "dsk_map.vh"

module dsk_bit_map (
    input  wire [9:0] pos_i,       // Bit position within the data field
    input  wire [1:0] fmt_i,       // B-field format
    input  wire       tail_ct_i,   // Tail carries control tail channel
    output reg        key_use_o,   // Position consumes one key bit
    output reg        xor_o        // Position is XORed with that key bit
);

    reg [9:0] bpos;
    reg [9:0] rem;
    reg       in_a;
    reg       in_b;
    integer   i;

    always @* begin
        bpos = pos_i - `DSK_A_LEN;
        in_a = (pos_i >= `DSK_A_KEY_FIRST) && (pos_i <= `DSK_A_KEY_LAST);
        in_b = (pos_i >= `DSK_A_LEN) && (bpos < `DSK_B_KEY_LEN);
        // Subfield offset, valid below 800
        rem = bpos;
        for (i = 0; i < `DSK_NSUB - 1; i = i + 1) begin
            if (rem >= `DSK_SUB_LEN) begin
                rem = rem - `DSK_SUB_LEN;
            end
        end
        // Key index runs 0..839 over these positions in order  [R01]
        key_use_o = in_a || in_b;
        xor_o     = 1'b0;
        if (in_a) begin
            xor_o = tail_ct_i;                           // [R02] [R03]
        end else if (in_b) begin
            case (fmt_i)
                `DSK_FMT_UNPROT: xor_o = 1'b1;           // [R04]
                `DSK_FMT_SINGLE: xor_o = bpos < `DSK_SINGLE_DATA; // [R05] [R08]
                `DSK_FMT_MULTI:  xor_o = rem < `DSK_SUB_DATA;     // [R06] [R09]
                default:         xor_o = 1'b0;
            endcase
        end
        // Check and X bits fall through with no XOR  [R07]
    end

endmodule

/* rtl/dsk_conn_mode.v */
// Cipher on/off state of one connection
// Assumes commands arrive as one-cycle strobes from the register file
`timescale 1ns/1ps
`include "dsk_map.vh"

module dsk_conn_mode #(
    parameter [2:0] IDX = 3'h0
) (
    input  wire        clk_i,      // Clock
    input  wire        rst_i,      // Synchronous reset, active high
    input  wire        ce_i,       // Clock enable
    input  wire        cmd_stb_i,  // Mode command strobe
    input  wire [2:0]  cmd_conn_i, // Connection named by the command
    input  wire        cmd_on_i,   // Requested mode
    input  wire [23:0] call_map_i, // Call group of each connection
    output reg         mode_o,     // Current mode of this connection
    output reg         ind_o       // Pulse: mode of this connection changed
);

    wire [2:0] my_call  = call_map_i[IDX*3 +: 3];
    wire [2:0] cmd_call = call_map_i[cmd_conn_i*3 +: 3];
    // Whole call follows the command, so its connections agree after each command; a call map write does not realign them
    wire       hit      = cmd_stb_i && ((cmd_conn_i == IDX) || (my_call == cmd_call)); // [R15]

    always @(posedge clk_i) begin
        if (rst_i) begin
            mode_o <= 1'b0;
            ind_o  <= 1'b0;
        end else if (ce_i) begin
            ind_o <= hit && (mode_o != cmd_on_i);
            if (hit) begin
                mode_o <= cmd_on_i;                      // [R13]
            end
        end
    end

endmodule

/* rtl/dsk_xor_top.v */
// Double slot key stream XOR with Wishbone registers
// Assumes bit-serial field data in lockstep with the key stream generator
//
// What this block does
// [R01] Two 840-bit segments per ciphered field pair
// [R02] Control tail: key 0-39 onto A bits 8-47
// [R03] Other tail: key 0-39 discarded, A unchanged
// [R04] Unprotected: key 40-839 onto B 0-799
// [R05] Single protected: key 40-807 onto B 0-767
// [R06] Multi protected: 64 data bits of each of ten 80-bit subfields ciphered
// [R07] Check bits and X bits never ciphered
// [R08] Single layout: 768 data, 32 check, 4 X
// [R09] Multi subfield: 64 data plus 16 check
// [R10] Segment pair per frame totals 1680 bits
// [R11] Each bearer ciphered separately, own init vector
// [R12] Double simplex: first field fixed, second portable
// [R13] Mode set per connection, applies to all bearers
// [R14] Mode reports describe whole connection
// [R15] Connections of one call share one mode
// [R16] Link access data unciphered unless via ciphered control
// [R17] Frame uses one fixed and one portable segment
// [R18] Receive path uses identical mapping
// [R19] Format and tail type latched per slot
`timescale 1ns/1ps
`include "dsk_map.vh"

module dsk_xor_top (
    input  wire        clk_i,              // Clock, 40 MHz
    input  wire        rst_i,              // Synchronous reset, active high
    input  wire        ce_i,               // Clock enable, freezes all state when low
    // Wishbone slave
    input  wire        wb_cyc_i,           // Bus cycle
    input  wire        wb_stb_i,           // Strobe
    input  wire        wb_we_i,            // Write enable
    input  wire [7:0]  wb_adr_i,           // Byte address
    input  wire [3:0]  wb_sel_i,           // Byte lanes
    input  wire [31:0] wb_dat_i,           // Write data
    output reg  [31:0] wb_dat_o,           // Read data
    output reg         wb_ack_o,           // Acknowledge
    // Slot set-up
    input  wire        slot_start_i,       // Pulse: new data field begins
    input  wire [1:0]  slot_fmt_i,         // B-field format
    input  wire        slot_tail_ct_i,     // Tail is control tail channel
    input  wire [2:0]  slot_bearer_i,      // Bearer number
    input  wire        slot_rx_i,          // Field is received, not sent
    input  wire        slot_simplex_i,     // Bearer is double simplex
    input  wire        slot_second_i,      // Second field of the frame
    input  wire        slot_dlae_i,        // Data from data-link access entity
    input  wire        slot_lc_route_i,    // Routed via link control entity
    input  wire [3:0]  frame_num_i,        // Frame number
    input  wire [23:0] mframe_num_i,       // Multiframe number
    input  wire        frame_start_i,      // Pulse: frame boundary
    // Field bit stream
    input  wire        bit_valid_i,        // Field bit valid
    input  wire        bit_i,              // Field bit
    output reg         dout_valid_o,       // Output bit valid
    output reg         dout_bit_o,         // Output bit
    output reg         dout_last_o,        // Last bit of the field
    // Key stream generator
    input  wire        ks_valid_i,         // Key bit valid
    input  wire        ks_bit_i,           // Key bit
    output reg         ks_ready_o,         // Next field bit consumes a key bit
    output reg         ks_seg_o,           // 0 fixed-side, 1 portable-side segment
    output reg  [2:0]  ks_bearer_o,        // Bearer whose generator is used
    output reg  [27:0] init_vector_o,      // Multiframe and frame number
    // Mode reports
    output wire [7:0]  cipher_mode_o,      // Mode of each connection
    output wire [7:0]  cipher_mode_ind_o,  // Pulse: connection mode changed
    output reg         cipher_mode_cfm_o   // Pulse: mode command completed
);

////////////////////////////////////////////////////////////////////////////////
// Register file

    reg  [31:0] ctrl_ff;
    reg  [23:0] bmap_ff;
    reg  [23:0] cmap_ff;
    reg         cmd_stb_ff;
    reg  [2:0]  cmd_conn_ff;
    reg         cmd_on_ff;
    reg  [10:0] key_cnt_ff;
    reg  [10:0] key_last_ff;
    reg         pair_ok_ff;
    reg         under_ff;

    wire        req      = wb_cyc_i && wb_stb_i;
    wire        wr_take  = req && wb_we_i && wb_ack_o;
    wire [7:0]  adr      = {wb_adr_i[7:2], 2'b00};
    reg  [31:0] nxt_rdat;
    reg         under_clr;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  sel;
        integer      k;
        begin
            for (k = 0; k < 4; k = k + 1) begin
                merge[k*8 +: 8] = sel[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
            end
        end
    endfunction

    wire [31:0] bmap_wr  = merge({8'h00, bmap_ff}, wb_dat_i, wb_sel_i);
    wire [31:0] cmap_wr  = merge({8'h00, cmap_ff}, wb_dat_i, wb_sel_i);

    always @* begin
        nxt_rdat = 32'h0000_0000;
        case (adr)
            `DSK_OFF_CTRL:   nxt_rdat = {31'h0000_0000, ctrl_ff[`DSK_CTRL_PT]};
            `DSK_OFF_MODE:   nxt_rdat = {24'h00_0000, cipher_mode_o}; // [R14]
            `DSK_OFF_BMAP:   nxt_rdat = {8'h00, bmap_ff};
            `DSK_OFF_CMAP:   nxt_rdat = {8'h00, cmap_ff};
            `DSK_OFF_STATUS: nxt_rdat = {14'h0000, under_ff, pair_ok_ff, 5'h00, key_last_ff};
            default:         nxt_rdat = 32'h0000_0000;
        endcase
    end

    always @* begin
        under_clr = wr_take && (adr == `DSK_OFF_STATUS) && wb_sel_i[2] &&
                    wb_dat_i[`DSK_STAT_UNDER];
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o    <= 1'b0;
            wb_dat_o    <= 32'h0000_0000;
            ctrl_ff     <= `DSK_RST_CTRL;
            bmap_ff     <= `DSK_RST_MAP;
            cmap_ff     <= `DSK_RST_MAP;
            cmd_stb_ff  <= 1'b0;
            cmd_conn_ff <= 3'h0;
            cmd_on_ff   <= 1'b0;
            cipher_mode_cfm_o <= 1'b0;
        end else if (ce_i) begin
            // Registered ack, one cycle
            wb_ack_o   <= req && !wb_ack_o;
            cmd_stb_ff <= 1'b0;
            // Confirm on the same edge as the cells
            cipher_mode_cfm_o <= cmd_stb_ff;                     // [R14]
            if (req && !wb_ack_o) begin
                wb_dat_o <= nxt_rdat;
            end
            // Writes land on the edge where the master sees ack
            if (wr_take) begin
                case (adr)
                    `DSK_OFF_CTRL: ctrl_ff <= merge(ctrl_ff, wb_dat_i, wb_sel_i);
                    `DSK_OFF_MODE: begin
                        if (wb_sel_i[0] && wb_sel_i[1]) begin
                            cmd_stb_ff  <= 1'b1;                 // [R13]
                            cmd_conn_ff <= wb_dat_i[2:0];
                            cmd_on_ff   <= wb_dat_i[`DSK_MODE_ON];
                        end
                    end
                    `DSK_OFF_BMAP: bmap_ff <= bmap_wr[23:0];
                    `DSK_OFF_CMAP: cmap_ff <= cmap_wr[23:0];
                    default: ;
                endcase
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Per-connection mode cells

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_conn
            dsk_conn_mode #(
                .IDX        (g[2:0])
            ) u_conn (
                .clk_i      (clk_i),
                .rst_i      (rst_i),
                .ce_i       (ce_i),
                .cmd_stb_i  (cmd_stb_ff),
                .cmd_conn_i (cmd_conn_ff),
                .cmd_on_i   (cmd_on_ff),
                .call_map_i (cmap_ff),
                .mode_o     (cipher_mode_o[g]),
                .ind_o      (cipher_mode_ind_o[g])
            );
        end
    endgenerate

////////////////////////////////////////////////////////////////////////////////
// Field sequencer

    reg        active_ff;
    reg  [9:0] pos_ff;
    reg  [9:0] last_ff;
    reg  [1:0] fmt_ff;
    reg        ct_ff;
    reg        cipher_ff;

    reg        nxt_active;
    reg  [9:0] nxt_pos;
    reg  [1:0] nxt_fmt;
    reg        nxt_ct;
    reg        nxt_cipher;
    reg        start_cipher;
    reg  [2:0] start_conn;

    wire       cur_key;
    wire       cur_xor;
    wire       nxt_key;

    always @* begin
        start_conn   = bmap_ff[slot_bearer_i*3 +: 3];
        // All bearers of a connection share its mode        [R13]
        // Link access data stays clear unless under ciphered control  [R16]
        start_cipher = cipher_mode_o[start_conn] && (!slot_dlae_i || slot_lc_route_i);
    end

    always @* begin
        nxt_active = active_ff;
        nxt_pos    = pos_ff;
        nxt_fmt    = fmt_ff;
        nxt_ct     = ct_ff;
        nxt_cipher = cipher_ff;
        if (slot_start_i) begin
            // A new start aborts any field still in flight
            nxt_active = 1'b1;
            nxt_pos    = 10'h000;
            nxt_fmt    = slot_fmt_i;                             // [R19]
            nxt_ct     = slot_tail_ct_i;
            nxt_cipher = start_cipher;
        end else if (active_ff && bit_valid_i) begin
            nxt_pos = pos_ff + 10'h001;
            if (pos_ff == last_ff) begin
                nxt_active = 1'b0;
            end
        end
    end

    dsk_bit_map u_map_cur (
        .pos_i     (pos_ff),
        .fmt_i     (fmt_ff),
        .tail_ct_i (ct_ff),
        .key_use_o (cur_key),
        .xor_o     (cur_xor)
    );

    // Looks one step ahead so the key request can come from a flop
    dsk_bit_map u_map_nxt (
        .pos_i     (nxt_pos),
        .fmt_i     (nxt_fmt),
        .tail_ct_i (nxt_ct),
        .key_use_o (nxt_key),
        .xor_o     ()
    );

    wire take = active_ff && bit_valid_i && cur_key && cipher_ff;

    always @(posedge clk_i) begin
        if (rst_i) begin
            active_ff     <= 1'b0;
            pos_ff        <= 10'h000;
            last_ff       <= `DSK_LAST_UNPROT;
            fmt_ff        <= `DSK_FMT_UNPROT;
            ct_ff         <= 1'b0;
            cipher_ff     <= 1'b0;
            ks_ready_o    <= 1'b0;
            ks_seg_o      <= 1'b0;
            ks_bearer_o   <= 3'h0;
            init_vector_o <= 28'h000_0000;
            dout_valid_o  <= 1'b0;
            dout_bit_o    <= 1'b0;
            dout_last_o   <= 1'b0;
        end else if (ce_i) begin
            active_ff  <= nxt_active;
            pos_ff     <= nxt_pos;
            fmt_ff     <= nxt_fmt;
            ct_ff      <= nxt_ct;
            cipher_ff  <= nxt_cipher;
            ks_ready_o <= nxt_active && nxt_key && nxt_cipher;
            if (slot_start_i) begin
                last_ff <= (slot_fmt_i == `DSK_FMT_UNPROT) ? `DSK_LAST_UNPROT
                                                           : `DSK_LAST_PROT;
                // Simplex: order of the field picks the segment  [R12] [R17]
                // Duplex: each side sends with its own segment
                ks_seg_o <= slot_simplex_i ? slot_second_i
                                           : (ctrl_ff[`DSK_CTRL_PT] ^ slot_rx_i);
                ks_bearer_o   <= slot_bearer_i;                  // [R11]
                init_vector_o <= {mframe_num_i, frame_num_i};    // [R11]
            end
            dout_valid_o <= active_ff && bit_valid_i;
            // Same XOR both ways, so receive restores the plain bits  [R18]
            dout_bit_o   <= bit_i ^ (take && ks_valid_i && cur_xor && ks_bit_i);
            dout_last_o  <= active_ff && bit_valid_i && (pos_ff == last_ff);
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Key usage per frame and underrun flag

    always @(posedge clk_i) begin
        if (rst_i) begin
            key_cnt_ff  <= 11'h000;
            key_last_ff <= 11'h000;
            pair_ok_ff  <= 1'b0;
            under_ff    <= 1'b0;
        end else if (ce_i) begin
            if (frame_start_i) begin
                key_cnt_ff  <= {10'h000, take};
                key_last_ff <= key_cnt_ff;
                pair_ok_ff  <= key_cnt_ff == `DSK_PAIR_LEN;      // [R10]
            end else if (take) begin
                key_cnt_ff <= key_cnt_ff + 11'h001;
            end
            // A missing key bit is flagged; the set beats a clear
            if (take && !ks_valid_i) begin
                under_ff <= 1'b1;
            end else if (under_clr) begin
                under_ff <= 1'b0;
            end
        end
    end

endmodule

/* verification/dsk_xor_asserts.sv */
// Checker for the key stream XOR block: bus, stream and mode timing
// Assumes a bind from the bench top onto the block's own ports
`timescale 1ns/1ps
module dsk_xor_asserts (
    input logic       clk_i,             // Clock
    input logic       rst_i,             // Synchronous reset
    input logic       ce_i,              // Clock enable
    input logic       wb_cyc_i,          // Bus cycle
    input logic       wb_stb_i,          // Strobe
    input logic       wb_we_i,           // Write enable
    input logic [7:0] wb_adr_i,          // Byte address
    input logic [3:0] wb_sel_i,          // Byte lanes
    input logic       wb_ack_o,          // Acknowledge
    input logic       slot_start_i,      // Field start
    input logic       bit_valid_i,       // Field bit valid
    input logic       dout_valid_o,      // Output bit valid
    input logic       dout_last_o,       // Last output bit
    input logic       ks_ready_o,        // Key bit wanted
    input logic [7:0] cipher_mode_o,     // Connection modes
    input logic [7:0] cipher_mode_ind_o, // Mode change pulses
    input logic       cipher_mode_cfm_o  // Command done pulse
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
    endsequence
    sequence s_mode_wr;
        wb_ack_o && wb_we_i && wb_stb_i && wb_adr_i[7:2] == 6'h01 && wb_sel_i[1:0] == 2'b11;
    endsequence
    sequence s_head;
        !ks_ready_o [*8];
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    a_ack_after_req: assert property (s_req |=> wb_ack_o)
        else $error("ack late");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_ack_has_req: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("stray ack");
    a_dout_has_bit: assert property (dout_valid_o |-> $past(bit_valid_i))
        else $error("stray output bit");
    a_last_is_valid: assert property (dout_last_o |-> dout_valid_o)
        else $error("stray last flag");
    a_head_no_key: assert property (slot_start_i |=> s_head)
        else $error("early key request");
    a_mode_after_wr: assert property ($changed(cipher_mode_o) |->
        $past(wb_ack_o && wb_we_i, 2)) else $error("mode change unasked");
    a_cfm_timing: assert property (s_mode_wr |-> ##2 cipher_mode_cfm_o)
        else $error("late confirm");
    a_ind_is_change: assert property (cipher_mode_ind_o ==
        (cipher_mode_o ^ $past(cipher_mode_o))) else $error("wrong indication");
    a_cfm_one_cycle: assert property (cipher_mode_cfm_o |=> !cipher_mode_cfm_o)
        else $error("confirm too long");
endmodule

/* verification/dsk_ks_model.sv */
// Key stream generator model: one bit per request, index per field
// Assumes the block asks via ks_ready and takes the bit in that cycle
`timescale 1ns/1ps
module dsk_ks_model (
    input  logic       clk_i,        // Clock
    input  logic       rst_i,        // Synchronous reset
    input  logic       slot_start_i, // New field restarts the index
    input  logic       bit_valid_i,  // Field bit taken
    input  logic       ks_ready_i,   // Block wants a key bit
    input  logic       ks_seg_i,     // Segment select
    input  logic [2:0] ks_bearer_i,  // Bearer generator
    input  logic       stall_i,      // Withhold key bits
    output logic       ks_valid_o,   // Key bit valid
    output logic       ks_bit_o      // Key bit
);
    int   idx_ff;
    logic alt_ff;
    // Segment and bearer enter so a wrong pick shows
    function automatic logic key_fn(input int i, input logic s, input logic [2:0] b);
        int v;
        v = i * 13 + s * 7 + b * 3 + i / 9;
        return ^v[7:0];
    endfunction
    always @(posedge clk_i) begin
        alt_ff <= rst_i ? 1'b0 : ~alt_ff;
        if (rst_i || slot_start_i)
            idx_ff <= 0;
        else if (bit_valid_i && ks_ready_i && ks_valid_o && idx_ff < 839)
            idx_ff <= idx_ff + 1;
    end
    assign ks_valid_o = ks_ready_i && !stall_i;
    // Idle line toggles so a stale bit never looks right
    assign ks_bit_o = ks_valid_o ? key_fn(idx_ff, ks_seg_i, ks_bearer_i) : alt_ff;
endmodule

/* verification/tb_top.sv */
// Bench top: registers, field streams and mode control of the XOR block
// Assumes the key model answers in the cycle the block asks
`timescale 1ns/1ps
module tb_top;
    logic        clk_i = 0, rst_i = 1, ce_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0]  wb_adr_i = 0, cmode = 0;
    logic [3:0]  wb_sel_i = 4'hF, frame_num_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o;
    logic        slot_start_i = 0, slot_tail_ct_i = 0, slot_rx_i = 0, slot_simplex_i = 0;
    logic        slot_second_i = 0, slot_dlae_i = 0, slot_lc_route_i = 0, frame_start_i = 0;
    logic [1:0]  slot_fmt_i = 0, bx_e;
    logic [2:0]  slot_bearer_i = 0, ks_bearer_o;
    logic [23:0] mframe_num_i = 0;
    logic        bit_valid_i = 0, bit_i = 0, stall = 0, port = 0, wb_ack_o;
    logic        dout_valid_o, dout_bit_o, dout_last_o, ks_valid_i, ks_bit_i;
    logic        ks_ready_o, ks_seg_o, cipher_mode_cfm_o;
    logic [27:0] init_vector_o;
    logic [7:0]  cipher_mode_o, cipher_mode_ind_o;
    logic [63:0] rx_e, rd_q[$];
    logic [1:0]  bit_q[$];
    int          error_cnt = 0, cmp_count = 0, seed = 43237;

    always #12.5 clk_i = ~clk_i;

    dsk_xor_top dsk_xor_top_i (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .slot_start_i, .slot_fmt_i,
        .slot_tail_ct_i, .slot_bearer_i, .slot_rx_i, .slot_simplex_i, .slot_second_i,
        .slot_dlae_i, .slot_lc_route_i, .frame_num_i, .mframe_num_i, .frame_start_i,
        .bit_valid_i, .bit_i, .dout_valid_o, .dout_bit_o, .dout_last_o, .ks_valid_i,
        .ks_bit_i, .ks_ready_o, .ks_seg_o, .ks_bearer_o, .init_vector_o, .cipher_mode_o,
        .cipher_mode_ind_o, .cipher_mode_cfm_o);

    dsk_ks_model dsk_ks_model_i (.clk_i, .rst_i, .slot_start_i,
        .bit_valid_i, .ks_ready_i(ks_ready_o), .ks_seg_i(ks_seg_o),
        .ks_bearer_i(ks_bearer_o), .stall_i(stall), .ks_valid_o(ks_valid_i),
        .ks_bit_o(ks_bit_i));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        if (error_cnt == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Reads expect d under mask m
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, m);
        int n;
        n = 0;
        if (!we) rd_q.push_back({m, d & m});
        @(posedge clk_i);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 50);
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
        if (n >= 50) error_cnt++;
    endtask

    task automatic field(input logic [2:0] b, input logic [1:0] f, input logic t, rx, sx, sc,
                         dl, lc, st);
        int   len, k, bp;
        logic ciph, x, d, s;
        ciph = cmode[b] && (!dl || lc) && !st;
        s    = sx ? sc : (rx ^ port);
        len  = (f == 2'h0) ? 864 : 868;
        @(posedge clk_i);
        slot_start_i <= 1;
        {slot_bearer_i, slot_fmt_i, slot_tail_ct_i, slot_rx_i} <= {b, f, t, rx};
        {slot_simplex_i, slot_second_i, slot_dlae_i, slot_lc_route_i, stall} <= {sx, sc, dl, lc, st};
        frame_num_i  <= $random(seed);
        mframe_num_i <= $random(seed);
        @(posedge clk_i);
        slot_start_i <= 0;
        for (int p = 0; p < len; p++) begin
            if (p == 1) begin
                chk({4'h0, init_vector_o}, {4'h0, mframe_num_i, frame_num_i});
                chk({29'h0, ks_bearer_o}, {29'h0, b});
            end
            d  = $random(seed);
            bp = p - 64;
            k  = (p < 48) ? p - 8 : p - 24;
            x  = ciph && ((p >= 8 && p < 48 && t) || (bp >= 0 && (f == 2'h0
                 || (f == 2'h1 && bp < 768) || (f == 2'h2 && bp < 800 && bp % 80 < 64))));
            bit_q.push_back({p == len - 1, d ^ (x && dsk_ks_model_i.key_fn(k, s, b))});
            bit_valid_i <= 1;
            bit_i       <= d;
            @(posedge clk_i);
        end
        bit_valid_i <= 0;
    endtask

    task automatic frame_mark;
        @(posedge clk_i);
        frame_start_i <= 1;
        @(posedge clk_i);
        frame_start_i <= 0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rd_q.size() > 0) begin
            rx_e = rd_q.pop_front();
            chk(wb_dat_o & rx_e[63:32], rx_e[31:0]);
        end
        if (dout_valid_o === 1'b1) begin
            bx_e = (bit_q.size() > 0) ? bit_q.pop_front() : 2'bxx;
            chk({30'h0, dout_last_o, dout_bit_o}, {30'h0, bx_e});
        end
    end

    initial begin
        repeat (40000) @(posedge clk_i);
        error_cnt++;
        close_out();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 0;
        for (int a = 0; a <= 32; a += 4) wb(0, a[7:0], 32'h0000_0000, 32'hFFFF_FFFF);
        wb(1, 8'h0C, 32'h0000_0048, 32'h0000_0000); // Conn 1 and 2 share a call
        wb(1, 8'h08, 32'h0000_0688, 32'h0000_0000); // Bearers 0-3 to conns 0-3, bearers 4-7 to conn 0
        wb(0, 8'h08, 32'h0000_0688, 32'h00FF_FFFF);
        wb(1, 8'h04, 32'h0000_0101, 32'h0000_0000);
        cmode = 8'h06;
        repeat (3) @(posedge clk_i);
        chk({24'h0, cipher_mode_o}, 32'h0000_0006);
        wb(0, 8'h04, 32'h0000_0006, 32'h0000_00FF);
        field(1, 2'h0, 1, 0, 0, 0, 0, 0, 0);
        field(2, 2'h1, 0, 1, 0, 0, 0, 0, 0);
        frame_mark();
        field(1, 2'h2, 1, 0, 1, 0, 0, 0, 0);
        field(2, 2'h2, 0, 1, 1, 1, 0, 0, 0);
        frame_mark();
        wb(0, 8'h10, 32'h0001_0690, 32'h0001_07FF);
        field(0, 2'h0, 1, 0, 0, 0, 0, 0, 0);
        field(1, 2'h0, 1, 0, 0, 0, 1, 0, 0);
        field(2, 2'h1, 1, 0, 0, 0, 1, 1, 0);
        wb(1, 8'h00, 32'h0000_0001, 32'h0000_0000);
        port = 1;
        wb(0, 8'h00, 32'h0000_0001, 32'h0000_0001);
        field(1, 2'h2, 1, 0, 0, 0, 0, 0, 0);
        field(1, 2'h0, 1, 0, 0, 0, 0, 0, 1);
        wb(0, 8'h10, 32'h0002_0000, 32'h0002_0000);
        wb(1, 8'h10, 32'h0002_0000, 32'h0000_0000);
        wb(0, 8'h10, 32'h0000_0000, 32'h0002_0000);
        wb(1, 8'h04, 32'h0000_0002, 32'h0000_0000);
        cmode = 8'h00;
        repeat (3) @(posedge clk_i);
        chk({24'h0, cipher_mode_o}, 32'h0000_0000);
        field(1, 2'h0, 1, 0, 0, 0, 0, 0, 0);
        repeat (5) @(posedge clk_i);
        if (bit_q.size() > 0 || rd_q.size() > 0) error_cnt++;
        close_out();
    end
endmodule

bind dsk_xor_top dsk_xor_asserts dsk_xor_asserts_i (.clk_i, .rst_i, .ce_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_ack_o, .slot_start_i, .bit_valid_i,
    .dout_valid_o, .dout_last_o, .ks_ready_o, .cipher_mode_o, .cipher_mode_ind_o,
    .cipher_mode_cfm_o);
